// ==== design/scd_clock_control.sv ====
// Slow clock and divider control: AXI4-Lite registers and clock-enable tree.
// Assumes every clock source arrives as a one-cycle aclk enable pulse,
// except clock_source_select, which is an asynchronous pin.
//
// Summary of operation
// - USB gate 0 runs PLL, 1 stops it
// - PLL power-down acts only in slow mode
// - Slow select picks input clock over PLL
// - Slow divide by twice value, zero passes
// - Input clock is crystal or external source
// - USB halve bit halves USB PLL clock
// - System bus ratio divides core clock
// - Quarter halve picks four or eight
// - Third halve picks three or six
// - Peripheral bus equals or halves system bus
// - Scaling runs CPU on system bus clock
// - Camera select bypasses or uses divider
// - Camera divides USB PLL by 2(f+1)
// - USB lock wait counts lock field cycles
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module scd_clock_control
    import scd_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        main_pll_tick,
    input  wire logic        usb_pll_tick,
    input  wire logic        crystal_input_tick,
    input  wire logic        external_clock_input_tick,
    input  wire logic        clock_source_select,
    output logic             core_clock_en,
    output logic             cpu_core_clock_en,
    output logic             system_bus_clock_en,
    output logic             peripheral_bus_clock_en,
    output logic             usb_clock_en,
    output logic             camera_clock_en,
    output logic             main_pll_power_down,
    output logic             usb_pll_power_down
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus

    logic [31:0] lock_reg, lock_next, slow_reg, slow_next;
    logic [31:0] bus_reg, bus_next, cam_reg, cam_next, status_word;
    logic        aw_have_reg, aw_have_next, w_have_reg, w_have_next;
    logic [31:0] aw_addr_reg, aw_addr_next, w_data_reg, w_data_next;
    logic [3:0]  w_strb_reg, w_strb_next;
    logic        awready_next, wready_next, arready_next;
    logic        bvalid_next, rvalid_next;
    logic [1:0]  bresp_next, rresp_next;
    logic [31:0] rdata_next;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
        return (old & ~m) | (data & m);
    endfunction

    always_comb begin
        lock_next    = lock_reg;
        slow_next    = slow_reg;
        bus_next     = bus_reg;
        cam_next     = cam_reg;
        aw_have_next = aw_have_reg;
        aw_addr_next = aw_addr_reg;
        w_have_next  = w_have_reg;
        w_data_next  = w_data_reg;
        w_strb_next  = w_strb_reg;
        bvalid_next  = s_axi_bvalid;
        bresp_next   = s_axi_bresp;
        rvalid_next  = s_axi_rvalid;
        rresp_next   = s_axi_rresp;
        rdata_next   = s_axi_rdata;
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        // Write done only once both halves are held and the old answer has gone
        if (aw_have_reg && w_have_reg && !s_axi_bvalid) begin
            aw_have_next = 1'b0;
            w_have_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = RESP_OKAY;
            case (aw_addr_reg)
                LOCK_TIME_ADDR: lock_next = merge(lock_reg, w_data_reg, w_strb_reg,
                                                  LOCK_TIME_MASK);
                SLOW_CTRL_ADDR: slow_next = merge(slow_reg, w_data_reg, w_strb_reg,
                                                  SLOW_CTRL_MASK);
                BUS_RATIO_ADDR: bus_next = merge(bus_reg, w_data_reg, w_strb_reg,
                                                 BUS_RATIO_MASK);
                CAM_DIV_ADDR:   cam_next = merge(cam_reg, w_data_reg, w_strb_reg,
                                                 CAM_DIV_MASK);
                STATUS_ADDR:    bresp_next = RESP_OKAY;
                default:        bresp_next = RESP_SLVERR;
            endcase
        end
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rresp_next  = RESP_OKAY;
            case (s_axi_araddr)
                LOCK_TIME_ADDR: rdata_next = lock_reg;
                SLOW_CTRL_ADDR: rdata_next = slow_reg;
                BUS_RATIO_ADDR: rdata_next = bus_reg;
                CAM_DIV_ADDR:   rdata_next = cam_reg;
                STATUS_ADDR:    rdata_next = status_word;
                default: begin
                    rdata_next = 32'h00000000;
                    rresp_next = RESP_SLVERR;
                end
            endcase
        end
        awready_next = !aw_have_next && !bvalid_next;
        wready_next  = !w_have_next && !bvalid_next;
        arready_next = !rvalid_next;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_reg      <= LOCK_TIME_RST;
            slow_reg      <= SLOW_CTRL_RST;
            bus_reg       <= BUS_RATIO_RST;
            cam_reg       <= CAM_DIV_RST;
            aw_have_reg   <= 1'b0;
            aw_addr_reg   <= 32'h00000000;
            w_have_reg    <= 1'b0;
            w_data_reg    <= 32'h00000000;
            w_strb_reg    <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= RESP_OKAY;
            s_axi_rdata   <= 32'h00000000;
        end else begin
            lock_reg      <= lock_next;
            slow_reg      <= slow_next;
            bus_reg       <= bus_next;
            cam_reg       <= cam_next;
            aw_have_reg   <= aw_have_next;
            aw_addr_reg   <= aw_addr_next;
            w_have_reg    <= w_have_next;
            w_data_reg    <= w_data_next;
            w_strb_reg    <= w_strb_next;
            s_axi_awready <= awready_next;
            s_axi_wready  <= wready_next;
            s_axi_arready <= arready_next;
            s_axi_bvalid  <= bvalid_next;
            s_axi_bresp   <= bresp_next;
            s_axi_rvalid  <= rvalid_next;
            s_axi_rresp   <= rresp_next;
            s_axi_rdata   <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Clock source pin and USB PLL lock wait

    logic           src_s1_reg, src_s2_reg, src_s3_reg, src_ext_reg, src_ext_next;
    scd_usb_state_e usb_state_reg, usb_state_next;
    logic [15:0]    lock_cnt_reg, lock_cnt_next;
    logic           slow_in_tick, usb_run;

    assign slow_in_tick = src_ext_reg ? external_clock_input_tick : crystal_input_tick;
    assign usb_run      = (usb_state_reg == SCD_USB_RUN);

    always_comb begin
        src_ext_next   = src_ext_reg;
        usb_state_next = usb_state_reg;
        lock_cnt_next  = lock_cnt_reg;
        // Pin change counts only once two later stages agree
        if (src_s2_reg == src_s3_reg) begin
            src_ext_next = src_s3_reg;
        end
        case (usb_state_reg)
            SCD_USB_OFF: begin
                if (!slow_reg[USB_GATE_BIT]) begin
                    usb_state_next = SCD_USB_LOCK;
                    lock_cnt_next  = lock_reg[LOCK_CNT_LSB +: 16];
                end
            end
            SCD_USB_LOCK: begin
                if (slow_reg[USB_GATE_BIT]) begin
                    usb_state_next = SCD_USB_OFF;
                end else if (lock_cnt_reg == 16'h0000) begin
                    usb_state_next = SCD_USB_RUN;
                end else if (slow_in_tick) begin
                    lock_cnt_next = lock_cnt_reg - 16'h0001;
                end
            end
            SCD_USB_RUN: begin
                if (slow_reg[USB_GATE_BIT]) begin
                    usb_state_next = SCD_USB_OFF;
                end
            end
            default: usb_state_next = SCD_USB_OFF;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_s1_reg    <= 1'b0;
            src_s2_reg    <= 1'b0;
            src_s3_reg    <= 1'b0;
            src_ext_reg   <= 1'b0;
            usb_state_reg <= SCD_USB_OFF;
            lock_cnt_reg  <= 16'h0000;
        end else begin
            src_s1_reg    <= clock_source_select;
            src_s2_reg    <= src_s1_reg;
            src_s3_reg    <= src_s2_reg;
            src_ext_reg   <= src_ext_next;
            usb_state_reg <= usb_state_next;
            lock_cnt_reg  <= lock_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Clock enable tree

    logic [2:0] slow_divide_value;
    logic [3:0] slow_div_m1, sys_div_m1;
    logic [4:0] cam_div_m1;
    logic       slow_tick, cam_div_tick, usb_src, main_pll_ok;
    logic       core_slow_reg, core_slow_next, dvs_reg, dvs_next, cam_sel_reg, cam_sel_next;
    logic       core_next, cpu_next, cam_next_en, mpd_next;

    assign slow_divide_value    = slow_reg[SLOW_DIVIDE_VALUE_LSB +: 3];
    assign slow_div_m1 = (slow_divide_value == 3'h0) ? 4'h0 : ({slow_divide_value, 1'b0} - 4'h1);
    assign cam_div_m1  = {cam_reg[CAM_FACTOR_LSB +: 4], 1'b1};
    assign usb_src     = usb_pll_tick && usb_run;
    assign main_pll_ok     = main_pll_tick && !main_pll_power_down;

    always_comb begin
        case (bus_reg[SYS_RATIO_LSB +: 2])
            2'h0:    sys_div_m1 = 4'h0;
            2'h1:    sys_div_m1 = 4'h1;
            2'h2:    sys_div_m1 = cam_reg[QUARTER_BIT] ? 4'h7 : 4'h3;
            2'h3:    sys_div_m1 = cam_reg[THIRD_BIT] ? 4'h5 : 4'h2;
            default: sys_div_m1 = 4'h0;
        endcase
    end

    // Selectors move on a tick of the source in use, ending its period; the camera selector also moves while USB is not running
    always_comb begin
        core_slow_next = core_slow_reg;
        dvs_next       = dvs_reg;
        cam_sel_next   = cam_sel_reg;
        core_next      = core_slow_reg ? slow_tick : main_pll_ok;
        if (core_next) begin
            core_slow_next = slow_reg[SLOW_SEL_BIT];
        end
        cpu_next = dvs_reg ? system_bus_clock_en : core_clock_en;
        if (cpu_next) begin
            dvs_next = cam_reg[SCALE_BIT];
        end
        cam_next_en = cam_sel_reg ? cam_div_tick : usb_src;
        if (cam_next_en || !usb_run) begin
            cam_sel_next = cam_reg[CAM_SEL_BIT];
        end
        // Hold PLL until core has moved to slow source, else core selector stalls
        mpd_next = slow_reg[PLL_PD_BIT] && slow_reg[SLOW_SEL_BIT] && core_slow_reg;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_slow_reg       <= 1'b0;
            dvs_reg             <= 1'b0;
            cam_sel_reg         <= 1'b0;
            core_clock_en       <= 1'b0;
            cpu_core_clock_en   <= 1'b0;
            camera_clock_en     <= 1'b0;
            main_pll_power_down <= 1'b0;
            usb_pll_power_down  <= 1'b1;
        end else begin
            core_slow_reg       <= core_slow_next;
            dvs_reg             <= dvs_next;
            cam_sel_reg         <= cam_sel_next;
            core_clock_en       <= core_next;
            cpu_core_clock_en   <= cpu_next;
            camera_clock_en     <= cam_next_en;
            main_pll_power_down <= mpd_next;
            usb_pll_power_down  <= (usb_state_next == SCD_USB_OFF);
        end
    end

    assign status_word = {27'h0000000, dvs_reg, src_ext_reg, main_pll_power_down,
                          core_slow_reg, usb_run};

    scd_tick_divider #(.W(4)) u_slow_div (.aclk(aclk), .aresetn(aresetn),
        .tick_in(slow_in_tick), .div_minus1(slow_div_m1), .tick_out(slow_tick));
    scd_tick_divider #(.W(4)) u_sys_div (.aclk(aclk), .aresetn(aresetn),
        .tick_in(core_clock_en), .div_minus1(sys_div_m1), .tick_out(system_bus_clock_en));
    scd_tick_divider #(.W(1)) u_periph_div (.aclk(aclk), .aresetn(aresetn),
        .tick_in(system_bus_clock_en), .div_minus1(bus_reg[PERIPH_BIT]),
        .tick_out(peripheral_bus_clock_en));
    scd_tick_divider #(.W(1)) u_usb_div (.aclk(aclk), .aresetn(aresetn),
        .tick_in(usb_src), .div_minus1(bus_reg[USB_HALVE_BIT]), .tick_out(usb_clock_en));
    scd_tick_divider #(.W(5)) u_cam_div (.aclk(aclk), .aresetn(aresetn),
        .tick_in(usb_src), .div_minus1(cam_div_m1), .tick_out(cam_div_tick));

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    pll_off_gate_a: assert property (!slow_reg[SLOW_SEL_BIT] |=> !main_pll_power_down)
        else $error("main PLL off outside slow mode");
    usb_stop_a: assert property (usb_pll_power_down [*3] |-> !usb_clock_en && !camera_clock_en)
        else $error("USB clock runs while PLL stopped");
    lock_done_a: assert property (usb_state_reg == SCD_USB_LOCK && lock_cnt_reg == 16'h0000
        && !slow_reg[USB_GATE_BIT] |=> usb_run) else $error("lock wait did not end");
    core_pll_a: assert property (!core_slow_reg && !main_pll_ok |=> !core_clock_en)
        else $error("core tick without PLL tick");
    core_slow_a: assert property (core_slow_reg && slow_tick |=> core_clock_en)
        else $error("slow tick not passed to core");
    slow_src_a: assert property (slow_tick |-> $past(slow_in_tick))
        else $error("slow tick without input clock");
    periph_src_a: assert property (peripheral_bus_clock_en |-> $past(system_bus_clock_en))
        else $error("peripheral tick without bus tick");
    cpu_scale_a: assert property (dvs_reg && !system_bus_clock_en |=> !cpu_core_clock_en)
        else $error("CPU tick off system bus tick");
    cam_bypass_a: assert property (!cam_sel_reg && usb_src |=> camera_clock_en)
        else $error("camera bypass lost tick");
    usb_src_a: assert property (usb_clock_en |-> $past(usb_src))
        else $error("USB tick without PLL tick");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");

    slow_entry_c: cover property (!core_slow_reg ##1 core_slow_reg);
    usb_lock_c:   cover property (usb_state_reg == SCD_USB_LOCK ##1 usb_run);
    pll_off_c:    cover property ($rose(main_pll_power_down));
    cam_div_c:    cover property (cam_sel_reg && camera_clock_en);

endmodule
`default_nettype wire

// ==== design/scd_pkg.sv ====
// Constants for the slow clock and divider control block.
// Assumes byte addressing on a 32-bit AXI4-Lite bus.
package scd_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [31:0] LOCK_TIME_ADDR  = 32'h4C000000;
    localparam logic [31:0] SLOW_CTRL_ADDR  = 32'h4C000010;
    localparam logic [31:0] BUS_RATIO_ADDR  = 32'h4C000014;
    localparam logic [31:0] CAM_DIV_ADDR    = 32'h4C000018;
    localparam logic [31:0] STATUS_ADDR     = 32'h4C00001C;

    // Reset values
    localparam logic [31:0] LOCK_TIME_RST   = 32'hFFFFFFFF;
    localparam logic [31:0] SLOW_CTRL_RST   = 32'h00000004;
    localparam logic [31:0] BUS_RATIO_RST   = 32'h00000000;
    localparam logic [31:0] CAM_DIV_RST     = 32'h00000000;

    // Writable bits; others read zero
    localparam logic [31:0] LOCK_TIME_MASK  = 32'hFFFFFFFF;
    localparam logic [31:0] SLOW_CTRL_MASK  = 32'h000000B7;
    localparam logic [31:0] BUS_RATIO_MASK  = 32'h0000000F;
    localparam logic [31:0] CAM_DIV_MASK    = 32'h0000131F;

    // Field positions
    localparam int USB_GATE_BIT    = 7;
    localparam int PLL_PD_BIT      = 5;
    localparam int SLOW_SEL_BIT    = 4;
    localparam int SLOW_DIVIDE_VALUE_LSB    = 0;
    localparam int USB_HALVE_BIT   = 3;
    localparam int SYS_RATIO_LSB   = 1;
    localparam int PERIPH_BIT      = 0;
    localparam int SCALE_BIT       = 12;
    localparam int QUARTER_BIT     = 9;
    localparam int THIRD_BIT       = 8;
    localparam int CAM_SEL_BIT     = 4;
    localparam int CAM_FACTOR_LSB  = 0;
    localparam int LOCK_CNT_LSB    = 16;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SCD_USB_OFF  = 2'h0,
        SCD_USB_LOCK = 2'h1,
        SCD_USB_RUN  = 2'h3
    } scd_usb_state_e;

endpackage

// ==== design/scd_tick_divider.sv ====
// Tick divider: one output pulse per (div_minus1 + 1) input pulses.
// Assumes tick_in is a one-cycle enable pulse on aclk.
`timescale 1ns/1ns
`default_nettype none
module scd_tick_divider #(
    parameter int W = 4
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         tick_in,
    input  wire logic [W-1:0] div_minus1,
    output logic              tick_out
);

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic [W-1:0] div_reg;
    logic [W-1:0] div_next;
    logic         out_next;

    // New ratio only taken at a period end, so no short period appears
    always_comb begin
        cnt_next = cnt_reg;
        div_next = div_reg;
        out_next = 1'b0;
        if (tick_in) begin
            if (cnt_reg >= div_reg) begin
                cnt_next = '0;
                div_next = div_minus1;
                out_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg  <= '0;
            div_reg  <= '0;
            tick_out <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            div_reg  <= div_next;
            tick_out <= out_next;
        end
    end

    tick_src_a: assert property (@(posedge aclk) disable iff (!aresetn)
        tick_out |-> $past(tick_in)) else $error("divider ticked without input");

endmodule
`default_nettype wire

// ==== verif/scd_clock_control_tb.sv ====
// Self-checking bench for the slow clock and divider control block.
// Assumes the DUT sees clock sources as aclk-domain tick pulses made here.
`timescale 1ns/1ns
`default_nettype none
module scd_clock_control_tb
    import scd_pkg::*;
;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, main_pll_tick, usb_pll_tick, crystal_input_tick;
    logic        external_clock_input_tick, clock_source_select, main_pll_power_down;
    logic        usb_pll_power_down, counting;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [2:0]  ph;
    wire  [5:0]  en;
    int          error_cnt, num_checks, cnt [6];
    string       nm [6] = '{"core", "system bus", "periph bus", "cpu", "usb", "camera"};
    // Columns: slow, bus, camera, source, then pulses per window: core sys per cpu usb cam
    int          rows [14][10] = '{
        '{'h00, 'h0, 'h000,  0, 240, 240, 240, 240, 240, 240},
        '{'h20, 'h3, 'h000,  0, 240, 120, 60,  240, 240, 240},
        '{'h00, 'h4, 'h000,  0, 240, 60,  60,  240, 240, 240},
        '{'h00, 'h4, 'h200,  0, 240, 30,  30,  240, 240, 240},
        '{'h00, 'h6, 'h000,  0, 240, 80,  80,  240, 240, 240},
        '{'h00, 'h6, 'h1100, 0, 240, 40,  40,  40,  240, 240},
        '{'h00, 'h8, 'h010,  0, 240, 240, 240, 240, 120, 120},
        '{'h00, 'h0, 'h012,  0, 240, 240, 240, 240, 240, 40},
        '{'h00, 'h0, 'h01F,  0, 240, 240, 240, 240, 240, 7},
        '{'h30, 'h0, 'h000,  1, 60,  60,  60,  60,  240, 240},
        '{'h10, 'h0, 'h000,  0, 120, 120, 120, 120, 240, 240},
        '{'h11, 'h0, 'h000,  0, 60,  60,  60,  60,  240, 240},
        '{'h14, 'h0, 'h000,  0, 15,  15,  15,  15,  240, 240},
        '{'h80, 'h0, 'h000,  0, 240, 240, 240, 240, 0,   0}
    };

    scd_clock_control DUT (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .main_pll_tick(main_pll_tick),
        .usb_pll_tick(usb_pll_tick), .crystal_input_tick(crystal_input_tick),
        .external_clock_input_tick(external_clock_input_tick),
        .clock_source_select(clock_source_select), .core_clock_en(en[0]),
        .system_bus_clock_en(en[1]), .peripheral_bus_clock_en(en[2]),
        .cpu_core_clock_en(en[3]), .usb_clock_en(en[4]), .camera_clock_en(en[5]),
        .main_pll_power_down(main_pll_power_down), .usb_pll_power_down(usb_pll_power_down)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // Fixed phases: main and USB at half rate, crystal quarter, external eighth
    always @(posedge aclk) begin
        ph                        <= ph + 3'h1;
        main_pll_tick             <= ph[0];
        usb_pll_tick              <= ~ph[0];
        crystal_input_tick        <= (ph[1:0] == 2'h3);
        external_clock_input_tick <= (ph == 3'h7);
        if (counting)
            for (int i = 0; i < 6; i++)
                cnt[i] += (en[i] === 1'b1);
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", n, exp, got);
        end
    endtask

    // Window phase against the tick pattern is arbitrary, so allow one pulse either way
    task automatic chk_rate(input string n, input int got, input int exp);
        num_checks++;
        if (got < exp - 1 || got > exp + 1) begin
            error_cnt++;
            $display("unexpected %s rate: expected %0d, seen %0d", n, exp, got);
        end
    endtask

    task automatic end_sim();
        if (error_cnt == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic timeout();
        chk("handshake wait", 32'h0, 32'h1);
        end_sim();
    endtask

    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
            s_axi_wvalid  <= s_axi_wvalid && !s_axi_wready;
            if (n == 64)
                timeout();
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("write response", {30'h0, s_axi_bresp}, {30'h0, er});
        @(posedge aclk);
    endtask

    task automatic axi_read(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
            if (n == 64)
                timeout();
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk("read data", s_axi_rdata, ed);
        chk("read response", {30'h0, s_axi_rresp}, {30'h0, er});
        @(posedge aclk);
    endtask

    // Settle past divider and lock changes, then count each enable over 480 cycles
    task automatic measure();
        repeat (48) @(posedge aclk);
        foreach (cnt[i])
            cnt[i] = 0;
        counting <= 1'b1;
        repeat (480) @(posedge aclk);
        counting <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
        {main_pll_tick, usb_pll_tick, crystal_input_tick, external_clock_input_tick} = 4'h0;
        clock_source_select = 1'b0;
        counting = 1'b0;
        ph = 3'h0;
        aresetn = 1'b0;
        error_cnt = 0;
        num_checks = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_read(SLOW_CTRL_ADDR, 32'h00000004, RESP_OKAY);
        axi_read(BUS_RATIO_ADDR, 32'h00000000, RESP_OKAY);
        axi_read(CAM_DIV_ADDR, 32'h00000000, RESP_OKAY);
        axi_read(32'h4C000020, 32'h00000000, RESP_SLVERR);
        axi_write(32'h4C000024, 32'hFFFFFFFF, RESP_SLVERR);
        axi_write(SLOW_CTRL_ADDR, 32'hFFFFFF4C, RESP_OKAY);
        axi_read(SLOW_CTRL_ADDR, 32'h00000004, RESP_OKAY);
        axi_write(BUS_RATIO_ADDR, 32'hFFFFFFFF, RESP_OKAY);
        axi_read(BUS_RATIO_ADDR, 32'h0000000F, RESP_OKAY);
        axi_write(CAM_DIV_ADDR, 32'hFFFFFFFF, RESP_OKAY);
        axi_read(CAM_DIV_ADDR, 32'h0000131F, RESP_OKAY);
        axi_write(LOCK_TIME_ADDR, 32'h0004FFFF, RESP_OKAY);
        // Restart the lock wait so the short count replaces the reset count
        axi_write(SLOW_CTRL_ADDR, 32'h00000080, RESP_OKAY);
        foreach (rows[r]) begin
            axi_write(BUS_RATIO_ADDR, rows[r][1], RESP_OKAY);
            axi_write(CAM_DIV_ADDR, rows[r][2], RESP_OKAY);
            axi_write(SLOW_CTRL_ADDR, rows[r][0], RESP_OKAY);
            clock_source_select <= rows[r][3][0];
            measure();
            for (int i = 0; i < 6; i++)
                chk_rate(nm[i], cnt[i], rows[r][4 + i]);
            chk("main pll off", {31'h0, main_pll_power_down},
                {31'h0, rows[r][0][5] & rows[r][0][4]});
            chk("usb pll off", {31'h0, usb_pll_power_down}, {31'h0, rows[r][0][7]});
        end
        axi_write(SLOW_CTRL_ADDR, 32'h00000000, RESP_OKAY);
        repeat (8) begin
            @(posedge aclk);
            chk("usb clock in lock wait", {31'h0, en[4]}, 32'h0);
        end
        measure();
        chk_rate(nm[4], cnt[4], 240);
        end_sim();
    end
endmodule
`default_nettype wire
